// ### gain_profile_pkg.sv
package gain_profile_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	localparam logic [7:0] OFS_IDX_RANGE  = 8'hB2;
	localparam logic [7:0] OFS_START_TIME = 8'hB3;
	localparam logic [7:0] OFS_HOLD_TIME  = 8'hB4;
	localparam logic [7:0] OFS_TRIG_CTRL  = 8'hB5;
	localparam logic [7:0] OFS_MODE_CTRL  = 8'hB6;
	localparam logic [7:0] OFS_WAIT_TIME  = 8'hB7;

	localparam logic [15:0] RST_IDX_RANGE  = 16'h009F;
	localparam logic [15:0] RST_ZERO       = 16'h0000;

	// trigger register fields
	localparam int TRIG_SLOPE0_POS   = 15;
	localparam int TRIG_INTSTART_POS = 14;
	localparam int TRIG_BANK_POS     = 12;
	localparam int TRIG_MANSTART_POS = 10;
	localparam int TRIG_GAIN_POS     = 0;
	// writable bits; reserved 11 and 9 and the self-clearing start bit drop
	localparam logic [15:0] TRIG_KEEP_MASK = 16'hF1FF;

	// mode register fields
	localparam int MODE_SEL_POS     = 14;
	localparam int MODE_PROF_POS    = 12;
	localparam int MODE_SRC_POS     = 11;
	localparam int MODE_RES_POS     = 7;
	localparam int MODE_ORDER_POS   = 6;
	localparam int MODE_ATTDIS_POS  = 5;
	localparam int MODE_SLOPE_POS   = 2;
	localparam logic [15:0] MODE_KEEP_MASK = 16'hFFFC;

	typedef enum logic [1:0] {
		MODE_EXT_NONUNIFORM,
		MODE_UPDOWN_RAMP,
		MODE_FIXED_GAIN,
		MODE_INT_NONUNIFORM
	} gain_mode_e;

	typedef struct packed {
		gain_mode_e  mode;
		logic [1:0]  profile;
		logic [1:0]  memBank;
		logic [3:0]  slopeFactor;
		logic [8:0]  fixedGainCode;
		logic [3:0]  inputResistanceSelect;
		logic        attenuatorOrderBit;
		logic        attenuatorEnable;
		logic [7:0]  startIndex;
		logic [7:0]  stopIndex;
		logic [15:0] startGainTime;
		logic [15:0] holdGainTime;
	} gain_cfg_s;
endpackage

// ### gain_profile_control_regs.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
// Contract
// (RQ1) The two-bit mode field picks external non-uniform, ramp, fixed gain or internal non-uniform sequencing.
// (RQ2) Profile source bit 0 takes the profile from the two pins, 1 takes it from the register field.
// (RQ3) The register profile field codes 00..11 pick profiles 0..3 and count only while register selection is on.
// (RQ4) Internal start enable 0 uses the external start, 1 makes the block generate periodic starts.
// (RQ5) Writing 1 to the manual start bit gives exactly one start pulse; writing 0 does nothing.
// (RQ6) The memory bank field picks the gain memory bank for internal non-uniform mode.
// (RQ7) In fixed gain mode the nine-bit manual gain code is the constant gain code.
// (RQ8) The four-bit slope factor is bit 15 of the trigger register plus bits 4-2 of the mode register.
// (RQ9) The attenuator order bit chooses attenuation first (0) or amplifier gain first (1).
// (RQ10) The attenuator disable bit 0 enables the input attenuator and 1 disables it.
// (RQ11) Software programs the input resistance select code matching the source resistance.
// (RQ12) Profile 3 start index sits in bits 15-8 resetting to 0, stop index in bits 7-0 resetting to 9Fh.
// (RQ13) The sixteen-bit profile 3 start gain time resets to zero and sets when the ramp starts.
// (RQ14) The sixteen-bit profile 3 hold gain time sets the hold duration.
// (RQ15) With internal start selected the start period comes from the sixteen-bit wait-time register.
// (RQ16) Software writes zero to reserved bits and the logic ignores them.
module gain_profile_control_regs
(
	input  wire logic                                   clk,
	input  wire logic                                   rst_b,
	input  wire logic [gain_profile_pkg::ADDR_W-1:0]    regAddr,
	input  wire logic [gain_profile_pkg::DATA_W-1:0]    regWrData,
	input  wire logic                                   regWrite,
	input  wire logic                                   regRead,
	output logic      [gain_profile_pkg::DATA_W-1:0]    regRdData,
	input  wire logic                                   extStart,
	input  wire logic                                   profile_pin_hi,
	input  wire logic                                   profile_pin_lo,
	output logic                                        seqStart,
	output gain_profile_pkg::gain_cfg_s                 gainCfg,
	output logic                                        fixedGainActive
);
	logic [15:0] idxRange_reg;
	logic [15:0] startTime_reg;
	logic [15:0] holdTime_reg;
	logic [15:0] trigCtrl_reg;
	logic [15:0] modeCtrl_reg;
	logic [15:0] waitTime_reg;
	logic [15:0] periodCnt_reg;
	logic [15:0] periodCnt_next;
	logic        manualPend_reg;
	logic        periodPulse;
	logic [1:0]  pinSync1_reg;
	logic [1:0]  pinSync2_reg;
	logic        extSync1_reg;
	logic        extSync2_reg;
	logic        extPrev_reg;
	logic        extEdge;
	logic        intStartEn;
	logic [1:0]  activeProfile;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return regWrite && (a == ofs);
	endfunction

	// pins are asynchronous to clk
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pinSync1_reg <= 2'h0;
			pinSync2_reg <= 2'h0;
			extSync1_reg <= 1'b0;
			extSync2_reg <= 1'b0;
			extPrev_reg  <= 1'b0;
		end
		else
		begin
			pinSync1_reg <= {profile_pin_hi, profile_pin_lo};
			pinSync2_reg <= pinSync1_reg;
			extSync1_reg <= extStart;
			extSync2_reg <= extSync1_reg;
			extPrev_reg  <= extSync2_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			idxRange_reg  <= gain_profile_pkg::RST_IDX_RANGE;
			startTime_reg <= gain_profile_pkg::RST_ZERO;
			holdTime_reg  <= gain_profile_pkg::RST_ZERO;
			trigCtrl_reg  <= gain_profile_pkg::RST_ZERO;
			modeCtrl_reg  <= gain_profile_pkg::RST_ZERO;
			waitTime_reg  <= gain_profile_pkg::RST_ZERO;
		end
		else
		begin
			if (hit(regAddr, gain_profile_pkg::OFS_IDX_RANGE))
				idxRange_reg <= regWrData; // RQ12
			if (hit(regAddr, gain_profile_pkg::OFS_START_TIME))
				startTime_reg <= regWrData; // RQ13
			if (hit(regAddr, gain_profile_pkg::OFS_HOLD_TIME))
				holdTime_reg <= regWrData; // RQ14
			if (hit(regAddr, gain_profile_pkg::OFS_TRIG_CTRL))
				trigCtrl_reg <= regWrData & gain_profile_pkg::TRIG_KEEP_MASK; // RQ16
			if (hit(regAddr, gain_profile_pkg::OFS_MODE_CTRL))
				modeCtrl_reg <= regWrData & gain_profile_pkg::MODE_KEEP_MASK; // RQ16
			if (hit(regAddr, gain_profile_pkg::OFS_WAIT_TIME))
				waitTime_reg <= regWrData; // RQ15
		end
	end

	// start bit is not stored; a write of 1 leaves one pending pulse
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			manualPend_reg <= 1'b0;
		else
			manualPend_reg <= hit(regAddr, gain_profile_pkg::OFS_TRIG_CTRL)
				&& regWrData[gain_profile_pkg::TRIG_MANSTART_POS]; // RQ5
	end

	assign intStartEn = trigCtrl_reg[gain_profile_pkg::TRIG_INTSTART_POS];

	// a wait time of zero still gives a start every cycle, never a stall
	always_comb
	begin
		periodCnt_next = periodCnt_reg;
		if (!intStartEn || periodPulse)
			periodCnt_next = 16'h0000;
		else
			periodCnt_next = periodCnt_reg + 16'h0001;
	end

	assign periodPulse = intStartEn && (periodCnt_reg >= waitTime_reg); // RQ15

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			periodCnt_reg <= 16'h0000;
		else
			periodCnt_reg <= periodCnt_next;
	end

	assign extEdge = extSync2_reg && !extPrev_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			seqStart <= 1'b0;
		else if (intStartEn)
			seqStart <= periodPulse || manualPend_reg; // RQ4
		else
			seqStart <= extEdge || manualPend_reg; // RQ4 RQ5
	end

	// pin path has two sync stages of latency
	assign activeProfile = modeCtrl_reg[gain_profile_pkg::MODE_SRC_POS]
		? modeCtrl_reg[gain_profile_pkg::MODE_PROF_POS +: 2] // RQ3
		: pinSync2_reg; // RQ2

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			gainCfg         <= '0;
			fixedGainActive <= 1'b0;
		end
		else
		begin
			gainCfg.mode <= gain_profile_pkg::gain_mode_e'(
				modeCtrl_reg[gain_profile_pkg::MODE_SEL_POS +: 2]); // RQ1
			gainCfg.profile <= activeProfile; // RQ2
			gainCfg.memBank <=
				trigCtrl_reg[gain_profile_pkg::TRIG_BANK_POS +: 2]; // RQ6
			gainCfg.slopeFactor <= {
				modeCtrl_reg[gain_profile_pkg::MODE_SLOPE_POS +: 3],
				trigCtrl_reg[gain_profile_pkg::TRIG_SLOPE0_POS]}; // RQ8
			gainCfg.fixedGainCode <=
				trigCtrl_reg[gain_profile_pkg::TRIG_GAIN_POS +: 9]; // RQ7
			gainCfg.inputResistanceSelect <=
				modeCtrl_reg[gain_profile_pkg::MODE_RES_POS +: 4]; // RQ11
			gainCfg.attenuatorOrderBit <=
				modeCtrl_reg[gain_profile_pkg::MODE_ORDER_POS]; // RQ9
			gainCfg.attenuatorEnable <=
				!modeCtrl_reg[gain_profile_pkg::MODE_ATTDIS_POS]; // RQ10
			gainCfg.startIndex    <= idxRange_reg[15:8]; // RQ12
			gainCfg.stopIndex     <= idxRange_reg[7:0]; // RQ12
			gainCfg.startGainTime <= startTime_reg; // RQ13
			gainCfg.holdGainTime  <= holdTime_reg; // RQ14
			fixedGainActive <= modeCtrl_reg[gain_profile_pkg::MODE_SEL_POS +: 2]
				== 2'h2; // RQ7
		end
	end

	// unmapped addresses read as zero
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			regRdData <= 16'h0000;
		else if (regRead)
			unique case (regAddr)
				gain_profile_pkg::OFS_IDX_RANGE:  regRdData <= idxRange_reg;
				gain_profile_pkg::OFS_START_TIME: regRdData <= startTime_reg;
				gain_profile_pkg::OFS_HOLD_TIME:  regRdData <= holdTime_reg;
				gain_profile_pkg::OFS_TRIG_CTRL:  regRdData <= trigCtrl_reg;
				gain_profile_pkg::OFS_MODE_CTRL:  regRdData <= modeCtrl_reg;
				gain_profile_pkg::OFS_WAIT_TIME:  regRdData <= waitTime_reg;
				default:                          regRdData <= 16'h0000;
			endcase
		else
			regRdData <= 16'h0000;
	end
endmodule // gain_profile_control_regs

// ### gain_profile_control_regs_chk.sv
`timescale 1ns/100ps
module gain_profile_control_regs_chk
(
	input logic                        clk,
	input logic                        rst_b,
	input logic [7:0]                  regAddr,
	input logic [15:0]                 regWrData,
	input logic                        regWrite,
	input logic                        regRead,
	input logic [15:0]                 regRdData,
	input logic                        extStart,
	input logic                        profile_pin_hi,
	input logic                        profile_pin_lo,
	input logic                        seqStart,
	input gain_profile_pkg::gain_cfg_s gainCfg,
	input logic                        fixedGainActive
);
	localparam logic [7:0] HOLD = gain_profile_pkg::OFS_HOLD_TIME;
	localparam logic [7:0] LAST = gain_profile_pkg::OFS_WAIT_TIME;
	wire modeWr = regWrite && regAddr == gain_profile_pkg::OFS_MODE_CTRL;
	wire trigWr = regWrite && regAddr == gain_profile_pkg::OFS_TRIG_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_hold_wr;
		regWrite && regAddr == HOLD ##1 !regWrite;
	endsequence
	sequence s_hold_rd;
		regRead && regAddr == HOLD;
	endsequence
	property p_unmap;
		regRead && regAddr > LAST |=> regRdData == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_hold_rb;
		s_hold_wr ##1 s_hold_rd |=> regRdData == $past(regWrData, 3);
	endproperty
	a_hold_rb: assert property (p_hold_rb) else $error("hold readback");
	property p_mode;
		modeWr |-> ##2 gainCfg.mode == $past(regWrData[15:14], 2)
			&& fixedGainActive == ($past(regWrData[15:14], 2) == 2'b10);
	endproperty
	a_mode: assert property (p_mode) else $error("mode field");
	property p_src;
		modeWr && regWrData[11] |-> ##2
			gainCfg.profile == $past(regWrData[13:12], 2);
	endproperty
	a_src: assert property (p_src) else $error("register profile");
	property p_att;
		modeWr |-> ##2 gainCfg.attenuatorEnable != $past(regWrData[5], 2)
			&& gainCfg.attenuatorOrderBit == $past(regWrData[6], 2);
	endproperty
	a_att: assert property (p_att) else $error("attenuator bits");
	property p_slope;
		modeWr |-> ##2 gainCfg.slopeFactor[3:1] == $past(regWrData[4:2], 2);
	endproperty
	a_slope: assert property (p_slope) else $error("slope high bits");
	property p_man;
		trigWr && regWrData[10] |-> ##2 seqStart;
	endproperty
	a_man: assert property (p_man) else $error("manual start");
	property p_gain;
		trigWr |-> ##2 gainCfg.fixedGainCode == $past(regWrData[8:0], 2)
			&& gainCfg.memBank == $past(regWrData[13:12], 2);
	endproperty
	a_gain: assert property (p_gain) else $error("gain code or bank");
endmodule // gain_profile_control_regs_chk
bind gain_profile_control_regs gain_profile_control_regs_chk chk_u (
	.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.extStart(extStart), .profile_pin_hi(profile_pin_hi),
	.profile_pin_lo(profile_pin_lo), .seqStart(seqStart),
	.gainCfg(gainCfg), .fixedGainActive(fixedGainActive));

// ### gain_host_model.sv
`timescale 1ns/100ps
module gain_host_model
(
	input  logic       clk,
	input  logic       startReq,
	input  logic [1:0] profSel,
	output logic       extStart,
	output logic       profile_pin_hi,
	output logic       profile_pin_lo
);
	// start is a level; only its rise may count, so hold shows no retrigger
	initial extStart = 1'b0;
	always @(posedge clk) extStart <= startReq;
	assign {profile_pin_hi, profile_pin_lo} = profSel;
endmodule // gain_host_model

// ### test_gain_profile_control_regs.sv
`timescale 1ns/100ps
module test_gain_profile_control_regs;
	localparam logic [7:0] MODE = gain_profile_pkg::OFS_MODE_CTRL;
	localparam logic [7:0] TRIG = gain_profile_pkg::OFS_TRIG_CTRL;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        startReq = 1'b0;
	logic [1:0]  profSel = 2'h0;
	logic [15:0] regRdData;
	logic        extStart, pinHi, pinLo, seqStart, fixedGainActive;
	gain_profile_pkg::gain_cfg_s gainCfg;
	int          errors = 0;
	int          n_checks = 0;
	int          seed = 32'h5CF519A2;
	int          n;
	logic [7:0]  a;
	logic [15:0] d;
	gain_profile_control_regs dut_u (.clk(clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .extStart(extStart),
		.profile_pin_hi(pinHi), .profile_pin_lo(pinLo), .seqStart(seqStart),
		.gainCfg(gainCfg), .fixedGainActive(fixedGainActive));
	gain_host_model host_u (.clk(clk), .startReq(startReq), .profSel(profSel),
		.extStart(extStart), .profile_pin_hi(pinHi), .profile_pin_lo(pinLo));
	initial forever #4 clk = ~clk;
	task results;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	function logic [15:0] expRd(input logic [7:0] a, input logic [15:0] d);
		if (a == TRIG)
			return d & gain_profile_pkg::TRIG_KEEP_MASK;
		if (a == MODE)
			return d & gain_profile_pkg::MODE_KEEP_MASK;
		return (a >= 8'hB2 && a <= 8'hB7) ? d : 16'h0000;
	endfunction
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	// bounded: a start that never comes must not hang the run
	task waitStart(output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			#1 c++;
		end
		while (seqStart !== 1'b1 && c < 20);
		if (c >= 20)
		begin
			errors++;
			results();
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(8'hB2 + 8'(i), i == 0 ? 16'h009F : 16'h0000);
		chk(16'({gainCfg.stopIndex, gainCfg.attenuatorEnable}), 16'h013F);
		repeat (24)
		begin
			a = 8'hB0 + 8'($unsigned($random(seed)) % 10);
			d = 16'($random(seed));
			wr(a, d);
			rd(a, expRd(a, d));
		end
		for (int m = 0; m < 4; m++)
		begin
			wr(MODE, {2'(m), 14'h1CF7});
			@(posedge clk);
			#1 chk(16'(gainCfg.mode), 16'(m));
			chk(16'(fixedGainActive), 16'(m == 2));
			chk(16'({gainCfg.inputResistanceSelect, gainCfg.attenuatorOrderBit,
				gainCfg.attenuatorEnable, gainCfg.profile}), 16'h0099);
		end
		wr(TRIG, 16'hA1A5);
		@(posedge clk);
		#1 chk(16'({gainCfg.slopeFactor, gainCfg.memBank,
			gainCfg.fixedGainCode}), 16'h5DA5);
		wr(MODE, 16'h0000);
		profSel <= 2'b10;
		repeat (4) @(posedge clk);
		#1 chk(16'(gainCfg.profile), 16'h0002);
		wr(MODE, 16'h3800);
		@(posedge clk);
		#1 chk(16'(gainCfg.profile), 16'h0003);
		wr(TRIG, 16'h0000);
		startReq <= 1'b1;
		waitStart(n);
		startReq <= 1'b0;
		chk(16'(n), 16'h0004);
		wr(TRIG, 16'h0400);
		@(posedge clk);
		#1 chk(16'(seqStart), 16'h0001);
		wr(TRIG, 16'h0000);
		repeat (4) @(posedge clk);
		#1 chk(16'(seqStart), 16'h0000);
		wr(8'hB7, 16'h0005);
		wr(TRIG, 16'h4000);
		waitStart(n);
		waitStart(n);
		chk(16'(n), 16'h0006);
		wr(TRIG, 16'h0000);
		wr(8'hB2, 16'h5A3C);
		wr(8'hB3, 16'h1234);
		wr(8'hB4, 16'hBEEF);
		@(posedge clk);
		#1 chk({gainCfg.startIndex, gainCfg.stopIndex}, 16'h5A3C);
		chk(gainCfg.startGainTime, 16'h1234);
		chk(gainCfg.holdGainTime, 16'hBEEF);
		// second reset in mid-run must restore the reset values
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'hB2, 16'h009F);
		rd(8'hB4, 16'h0000);
		results();
	end
endmodule // test_gain_profile_control_regs
